// file: shared/ssc_pkg.sv
// Constants and types shared by the serial port controller.
// Assumes a single core clock; no bus, all settings arrive as ports.
package ssc_pkg;
    localparam int unsigned FIFO_DEPTH  = 16;
    localparam int unsigned FIFO_WIDTH  = 32;
    localparam int unsigned FIFO_AW     = 4;
    localparam int unsigned SS_WIDE     = 4;
    localparam int unsigned DIV_WIDTH   = 8;
    localparam logic [7:0]  DIV_RESET   = 8'h00;
    localparam int unsigned IRQ_COUNT   = 8;
    localparam int unsigned IRQ_RX_FULL = 0;
    localparam int unsigned IRQ_RX_HALF = 1;
    localparam int unsigned IRQ_RX_NE   = 2;
    localparam int unsigned IRQ_TX_NF   = 3;
    localparam int unsigned IRQ_TX_HE   = 4;
    localparam int unsigned IRQ_TX_E    = 5;
    localparam int unsigned IRQ_ERR     = 6;
    localparam int unsigned IRQ_SS      = 7;

    typedef enum logic [1:0]
    {
        SSC_LEN_8,
        SSC_LEN_16,
        SSC_LEN_32,
        SSC_LEN_RSVD
    } ssc_len_t;

    function automatic logic [5:0] ssc_bits(input ssc_len_t len);
        unique case (len)
            SSC_LEN_8:  ssc_bits = 6'h08;
            SSC_LEN_16: ssc_bits = 6'h10;
            default:    ssc_bits = 6'h20;
        endcase
    endfunction
endpackage

// file: sim/spi_master_slave_controller_tb_top.sv
// Self-checking bench for the serial port controller, master and slave roles.
// Assumes ssc_pkg, ssc_ctrl and the ssc_peer model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module spi_master_slave_controller_tb_top;
    import ssc_pkg::*;
    localparam logic [31:0] PSEED = 32'h5A3C_C3A5;
    logic core_clk, arst_n, cfg_enable, cfg_master, tx_valid, tx_ready, rx_valid, rx_ready;
    logic irq_req, sclk_o, sclk_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, ss_in_n, b_mosi;
    logic sclk_w, mosi_w, miso_w, p_miso, b_sclk;
    ssc_len_t    cfg_len;
    logic [7:0]  cfg_div, irq_enable, irq_status, e, sw;
    logic [3:0]  cfg_ss_sel, ss_out_n;
    logic [31:0] tx_data, rx_data, got, hist = PSEED, lf = 32'hEED8_0E6A;
    logic [5:0]  p_bits;
    int          got_n, nb_cur, n_errors = 0, cmp_count = 0, hcnt = 0;
    logic [31:0] exp_mo[$], exp_rx[$];
    ssc_len_t    lens [5] = '{SSC_LEN_8, SSC_LEN_16, SSC_LEN_32, SSC_LEN_RSVD, SSC_LEN_8};
    int          nbt  [5] = '{8, 16, 32, 32, 8};
    logic [7:0]  divs [5] = '{8'h02, 8'h05, 8'h03, 8'h02, 8'hFF};
    logic [3:0]  sels [5] = '{4'h1, 4'h3, 4'h5, 4'h9, 4'hF};

    assign sclk_w = sclk_oe_n ? b_sclk : sclk_o;
    assign mosi_w = mosi_oe_n ? b_mosi : mosi_o;
    assign miso_w = miso_oe_n ? p_miso : miso_o;

    ssc_ctrl #(.SS_COUNT(4)) ssc_ctrl_inst (.core_clk(core_clk), .arst_n(arst_n),
        .cfg_enable(cfg_enable), .cfg_master(cfg_master), .cfg_len(cfg_len),
        .cfg_div(cfg_div), .cfg_ss_sel(cfg_ss_sel), .irq_enable(irq_enable),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_data(rx_data), .irq_status(irq_status), .irq_req(irq_req),
        .sclk_o(sclk_o), .sclk_oe_n(sclk_oe_n), .sclk_i(sclk_w), .mosi_o(mosi_o),
        .mosi_oe_n(mosi_oe_n), .mosi_i(mosi_w), .miso_i(miso_w), .miso_o(miso_o),
        .miso_oe_n(miso_oe_n), .ss_out_n(ss_out_n), .ss_in_n(ss_in_n));

    ssc_peer #(.SEED(PSEED)) ssc_peer_inst (.sclk(sclk_w), .mosi(mosi_w),
        .ss_n(ss_out_n[0]), .miso(p_miso), .nbits(p_bits), .got(got), .got_n(got_n));

    function automatic logic [31:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction

    function automatic logic [7:0] st(input int t, input int r);
        st = 8'h00;
        st[IRQ_RX_FULL] = (r == 16);
        st[IRQ_RX_HALF] = (r >= 8);
        st[IRQ_RX_NE] = (r > 0);
        st[IRQ_TX_NF] = (t < 16);
        st[IRQ_TX_HE] = (t <= 8);
        st[IRQ_TX_E] = (t == 0);
    endfunction

    task automatic chk_word(input string n, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic chk_bit(input string n, input logic x, input logic g);
        cmp_count++;
        if (g !== x)
        begin
            n_errors++;
            $display("MISMATCH %s expected %b seen %b", n, x, g);
        end
    endtask

    task automatic set_cfg(input ssc_len_t l, input int n, input logic [7:0] d,
                           input logic [3:0] s);
        @(negedge core_clk);
        cfg_len = l;
        nb_cur = n;
        p_bits = 6'(n);
        cfg_div = d;
        cfg_ss_sel = s;
    endtask

    // Notes what the far side must see and what must come back, then offers the word.
    task automatic push(input logic [31:0] w);
        logic [31:0] m;
        int          k;
        m = (nb_cur >= 32) ? 32'hFFFF_FFFF : ((32'h1 << nb_cur) - 32'h1);
        k = 0;
        exp_mo.push_back(w & m);
        exp_rx.push_back(hist & m);
        hist = (hist << nb_cur) | (w & m);
        @(negedge core_clk);
        tx_valid = 1'b1;
        tx_data = w;
        do
        begin
            @(posedge core_clk);
            k++;
        end
        while (tx_ready !== 1'b1 && k < 5000);
        @(negedge core_clk);
        tx_valid = 1'b0;
    endtask

    task automatic wait_idle(input bit rx_too);
        int k;
        k = 0;
        while ((exp_mo.size() != 0 || (rx_too && exp_rx.size() != 0)) && k < 40000)
        begin
            @(negedge core_clk);
            k++;
        end
        chk_bit("queues_drained", 1'b1, k < 40000);
        repeat (10) @(negedge core_clk);
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(got_n)
        if (got_n > 0)
            chk_word("mosi_word", exp_mo.size() ? exp_mo.pop_front() : 'x, got);

    always @(posedge core_clk)
        if (arst_n && rx_valid === 1'b1 && rx_ready === 1'b1)
            chk_word("rx_data", exp_rx.size() ? exp_rx.pop_front() : 'x, rx_data);

    // Counts the high phase of the serial clock and checks selects as it begins.
    always @(posedge core_clk)
    begin
        if (sclk_o === 1'b1)
        begin
            if (hcnt == 0)
            begin
                chk_word("ss_out_n", {28'h0, ~cfg_ss_sel}, {28'h0, ss_out_n});
                chk_bit("miso_oe_n", 1'b1, miso_oe_n);
            end
            hcnt++;
        end
        else if (hcnt != 0)
        begin
            chk_word("high_ticks", {24'h0, cfg_div} + 32'h1, hcnt);
            hcnt = 0;
        end
    end

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    initial
    begin
        repeat (60000) @(posedge core_clk);
        n_errors++;
        $display("MISMATCH watchdog expected finish seen timeout");
        conclude();
    end

    initial
    begin
        {arst_n, cfg_enable, tx_valid, b_mosi, b_sclk} = 5'h00;
        {cfg_master, rx_ready, ss_in_n} = 3'h7;
        cfg_len = SSC_LEN_8;
        cfg_div = 8'h02;
        cfg_ss_sel = 4'h1;
        irq_enable = 8'h00;
        tx_data = 32'h0;
        p_bits = 6'h08;
        nb_cur = 8;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        arst_n = 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            set_cfg(lens[i], nbt[i], divs[i], sels[i]);
            cfg_enable = 1'b1;
            repeat (3) push(rnd());
            wait_idle(1'b1);
            $display("test sweep %0d done", i);
        end
        set_cfg(SSC_LEN_8, 8, 8'h02, 4'h1);
        cfg_enable = 1'b0;
        for (int l = 0; l <= 16; l++)
        begin
            irq_enable = 8'(rnd());
            repeat (3) @(negedge core_clk);
            e = st(l, 0);
            chk_word("irq_status", {24'h0, e}, {24'h0, irq_status});
            chk_bit("irq_req", |(e & irq_enable), irq_req);
            chk_bit("tx_ready", l < 16, tx_ready);
            if (l < 16)
                push(rnd());
        end
        $display("test fill done");
        rx_ready = 1'b0;
        cfg_enable = 1'b1;
        wait_idle(1'b0);
        chk_word("irq_status", {24'h0, st(0, 16)}, {24'h0, irq_status});
        chk_bit("rx_valid", 1'b1, rx_valid);
        rx_ready = 1'b1;
        wait_idle(1'b1);
        $display("test drain done");
        cfg_master = 1'b0;
        b_mosi = 1'(rnd());
        repeat (5) @(negedge core_clk);
        chk_bit("miso_oe_n", 1'b1, miso_oe_n);
        chk_bit("sclk_oe_n", 1'b1, sclk_oe_n);
        ss_in_n = 1'b0;
        repeat (3) @(negedge core_clk);
        chk_bit("miso_oe_n", 1'b0, miso_oe_n);
        chk_bit("ss_event", 1'b1, irq_status[IRQ_SS]);
        // An outside master clocks one word in, most significant bit first.
        sw = 8'(rnd());
        exp_rx.push_back({24'h0, sw});
        for (int b = 7; b >= 0; b--)
        begin
            b_mosi = sw[b];
            repeat (4) @(negedge core_clk);
            b_sclk = 1'b1;
            repeat (4) @(negedge core_clk);
            b_sclk = 1'b0;
        end
        wait_idle(1'b1);
        ss_in_n = 1'b1;
        repeat (5) @(negedge core_clk);
        chk_bit("miso_oe_n", 1'b1, miso_oe_n);
        $display("test slave done");
        conclude();
    end
endmodule
`default_nettype wire

// file: sim/ssc_peer.sv
// Far-side model: a mode 0 slave that answers with the bits it last received.
// Assumes the controller selects it on ss_n and holds sclk low between frames.
`timescale 1ns/1ps
`default_nettype none
module ssc_peer #(
    parameter logic [31:0] SEED = 32'h5A3C_C3A5
) (
    // Serial side
    input  wire logic       sclk,
    input  wire logic       mosi,
    input  wire logic       ss_n,
    output logic            miso,
    // Bench side
    input  wire logic [5:0] nbits,
    output logic [31:0]     got,
    output var int          got_n
);
    logic [31:0] shreg  = SEED;
    logic [31:0] hist   = SEED;
    logic        pend   = 1'b0;
    logic        idle_v = 1'b0;
    int          cnt    = 0;

    initial got_n = 0;
    initial got = 32'h0;

    // Bits are taken on the rising edge, first bit most significant.
    always @(posedge sclk)
    begin
        if (!ss_n)
        begin
            hist = {hist[30:0], mosi};
            cnt++;
            if (cnt == int'(nbits))
            begin
                got = (nbits == 6'h20) ? hist : hist & ((32'h1 << nbits) - 32'h1);
                got_n++;
                cnt = 0;
                pend = 1'b1;
            end
        end
    end

    // The reply moves on the falling edge; a finished word becomes the next reply.
    always @(negedge sclk)
    begin
        if (!ss_n)
        begin
            if (pend)
                shreg = hist;
            else
                shreg = shreg << 1;
            pend = 1'b0;
        end
    end

    always @(negedge ss_n)
    begin
        cnt = 0;
        if (pend)
            shreg = hist;
        pend = 1'b0;
    end

    // When released the line no longer holds the last level.
    always @(posedge ss_n) idle_v = ~shreg[nbits - 6'h01];
    assign miso = ss_n ? idle_v : shreg[nbits - 6'h01];
endmodule
`default_nettype wire

// file: src/ssc_ctrl.sv
// Serial port controller: master or slave, 8/16/32 bit words, MSB first, mode 0.
// Assumes pins arrive unsynchronised and software settings are on core_clk.
`timescale 1ns/1ps
`default_nettype none
module ssc_ctrl
    import ssc_pkg::*;
#(
    parameter int unsigned SS_COUNT = ssc_pkg::SS_WIDE
) (
    // Clock and reset
    input  wire logic                          core_clk,
    input  wire logic                          arst_n,
    // Configuration
    input  wire logic                          cfg_enable,
    input  wire logic                          cfg_master,
    input  wire ssc_pkg::ssc_len_t             cfg_len,
    input  wire logic [ssc_pkg::DIV_WIDTH-1:0] cfg_div,
    input  wire logic [SS_COUNT-1:0]           cfg_ss_sel,
    input  wire logic [ssc_pkg::IRQ_COUNT-1:0] irq_enable,
    // Transmit words
    input  wire logic                          tx_valid,
    output logic                               tx_ready,
    input  wire logic [31:0]                   tx_data,
    // Receive words
    output logic                               rx_valid,
    input  wire logic                          rx_ready,
    output logic [31:0]                        rx_data,
    // Status
    output logic [ssc_pkg::IRQ_COUNT-1:0]      irq_status,
    output logic                               irq_req,
    // Serial pins
    output logic                               sclk_o,
    output logic                               sclk_oe_n,
    input  wire logic                          sclk_i,
    output logic                               mosi_o,
    output logic                               mosi_oe_n,
    input  wire logic                          mosi_i,
    input  wire logic                          miso_i,
    output logic                               miso_o,
    output logic                               miso_oe_n,
    output logic [SS_COUNT-1:0]                ss_out_n,
    input  wire logic                          ss_in_n
);
    import ssc_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} ssc_state_t;

    logic                  sclk_m1, sclk_s, sclk_sd;
    logic                  mosi_m1, mosi_s;
    logic                  miso_m1, miso_s;
    logic                  ss_m1, ss_s, ss_sd;
    ssc_state_t            st_q;
    logic [DIV_WIDTH-1:0]  div_q;
    logic                  tick;
    logic [31:0]           sh_q;
    logic [5:0]            cnt_q;
    logic [5:0]            nbits;
    logic                  rx_push;
    logic                  rx_in_ready;
    logic [31:0]           rx_word_q;
    logic                  tx_pop;
    logic                  tx_valid_f;
    logic [31:0]           tx_word;
    logic [31:0]           tx_data_f;
    logic [FIFO_AW:0]      rx_lvl, tx_lvl;
    logic                  err_ev;
    logic                  s_rise, s_fall;
    logic                  sin;
    logic [IRQ_COUNT-1:0]  ev;

    // Pin inputs pass two flip-flops before any use.
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            {sclk_m1, sclk_s, sclk_sd} <= 3'h0;
            {mosi_m1, mosi_s}          <= 2'h0;
            {miso_m1, miso_s}          <= 2'h0;
            {ss_m1, ss_s, ss_sd}       <= 3'h7;
        end
        else
        begin
            sclk_m1 <= sclk_i;
            sclk_s  <= sclk_m1;
            sclk_sd <= sclk_s;
            mosi_m1 <= mosi_i;
            mosi_s  <= mosi_m1;
            miso_m1 <= miso_i;
            miso_s  <= miso_m1;
            ss_m1   <= ss_in_n;
            ss_s    <= ss_m1;
            ss_sd   <= ss_s;
        end
    end

    assign nbits  = ssc_bits(cfg_len);
    assign s_rise = sclk_s && !sclk_sd;
    assign s_fall = !sclk_s && sclk_sd;
    assign sin    = cfg_master ? miso_s : mosi_s;

    // Half-period enable: div+1 core cycles per half period.
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            div_q <= DIV_RESET;
        else if (st_q == ST_IDLE || div_q == cfg_div)
            div_q <= DIV_RESET;
        else
            div_q <= div_q + 1'b1;
    end
    assign tick = (st_q != ST_IDLE) && (div_q == cfg_div);

    assign tx_word = tx_valid_f ? tx_data_f : 32'h0;

    // Shift engine, mode 0, MSB first, left-aligned in the shift register.
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q      <= ST_IDLE;
            sh_q      <= 32'h0;
            cnt_q     <= 6'h00;
            rx_word_q <= 32'h0;
        end
        else if (!cfg_enable)
            st_q <= ST_IDLE;
        else if (cfg_master)
        begin
            unique case (st_q)
                ST_IDLE:
                    if (tx_valid_f && rx_in_ready)
                    begin
                        sh_q      <= tx_word << (6'h20 - nbits);
                        cnt_q     <= 6'h00;
                        rx_word_q <= 32'h0;
                        st_q      <= ST_LOW;
                    end
                ST_LOW:
                    if (tick)
                        st_q <= ST_HIGH;
                // The input bit is taken at the end of the high phase, so the
                // output register and the two-flop synchroniser fit inside one
                // full period; a divider of zero leaves too little time for that.
                ST_HIGH:
                    if (tick)
                    begin
                        rx_word_q <= {rx_word_q[30:0], miso_s};
                        sh_q  <= {sh_q[30:0], 1'b0};
                        cnt_q <= cnt_q + 1'b1;
                        st_q  <= (cnt_q + 1'b1 == nbits) ? ST_IDLE : ST_LOW;
                    end
                default:
                    st_q <= ST_IDLE;
            endcase
        end
        else
        begin
            st_q <= ST_IDLE;
            if (ss_s)
            begin
                cnt_q     <= 6'h00;
                rx_word_q <= 32'h0;
            end
            else if (s_rise)
                rx_word_q <= {rx_word_q[30:0], sin};
            else if (s_fall)
            begin
                if (cnt_q + 1'b1 == nbits)
                    rx_word_q <= 32'h0;
                sh_q  <= {sh_q[30:0], 1'b0};
                cnt_q <= (cnt_q + 1'b1 == nbits) ? 6'h00 : cnt_q + 1'b1;
            end
            if (ss_s || (s_fall && cnt_q + 1'b1 == nbits))
                sh_q <= tx_word << (6'h20 - nbits);
        end
    end

    assign rx_push = cfg_master ? (st_q == ST_HIGH && tick && cnt_q + 1'b1 == nbits)
                                : (!ss_s && s_fall && cnt_q + 1'b1 == nbits);
    assign tx_pop  = tx_valid_f && (cfg_master ? (st_q == ST_IDLE && rx_in_ready && cfg_enable)
                                               : (!ss_s && s_fall && cnt_q + 1'b1 == nbits));
    // Error: receive overflow, or a slave frame cut off mid-word.
    assign err_ev  = (rx_push && !rx_in_ready)
                   || (!cfg_master && ss_s && !ss_sd && cnt_q != 6'h00);

    ssc_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_tx_fifo (
        .core_clk  (core_clk),
        .arst_n    (arst_n),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   (tx_data),
        .out_valid (tx_valid_f),
        .out_ready (tx_pop),
        .out_data  (tx_data_f),
        .level     (tx_lvl)
    );

    ssc_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_rx_fifo (
        .core_clk  (core_clk),
        .arst_n    (arst_n),
        .in_valid  (rx_push),
        .in_ready  (rx_in_ready),
        .in_data   (cfg_master ? {rx_word_q[30:0], miso_s} : rx_word_q),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data),
        .level     (rx_lvl)
    );

    // Pin drive; enables low while driving.
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sclk_o    <= 1'b0;
            sclk_oe_n <= 1'b1;
            mosi_o    <= 1'b0;
            mosi_oe_n <= 1'b1;
            miso_o    <= 1'b0;
            miso_oe_n <= 1'b1;
            ss_out_n  <= '1;
        end
        else
        begin
            sclk_o    <= (st_q == ST_HIGH);
            sclk_oe_n <= !(cfg_enable && cfg_master);
            mosi_o    <= sh_q[31];
            mosi_oe_n <= !(cfg_enable && cfg_master);
            miso_o    <= sh_q[31];
            miso_oe_n <= !(cfg_enable && !cfg_master && !ss_s);
            ss_out_n  <= (cfg_enable && cfg_master && st_q != ST_IDLE) ? ~cfg_ss_sel : '1;
        end
    end

    assign ev[IRQ_RX_FULL] = (rx_lvl == (FIFO_AW+1)'(FIFO_DEPTH));
    assign ev[IRQ_RX_HALF] = (rx_lvl >= (FIFO_AW+1)'(FIFO_DEPTH/2));
    assign ev[IRQ_RX_NE]   = rx_valid;
    assign ev[IRQ_TX_NF]   = tx_ready;
    assign ev[IRQ_TX_HE]   = (tx_lvl <= (FIFO_AW+1)'(FIFO_DEPTH/2));
    assign ev[IRQ_TX_E]    = !tx_valid_f;
    assign ev[IRQ_ERR]     = err_ev;
    assign ev[IRQ_SS]      = !ss_s && ss_sd;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_status <= '0;
            irq_req    <= 1'b0;
        end
        else
        begin
            irq_status <= ev;
            irq_req    <= |(ev & irq_enable);
        end
    end

    sclk_rate_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (st_q == ST_LOW && $past(st_q) == ST_HIGH) |-> $past(tick))
        else $error("clock phase moved without divider tick");
    miso_hiz_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        $past(ss_s) |-> miso_oe_n)
        else $error("miso driven while unselected");
    irq_gate_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        irq_req == |($past(ev) & $past(irq_enable)))
        else $error("interrupt request mismatch");
    ss_idle_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        $past(st_q) == ST_IDLE |-> ss_out_n == '1)
        else $error("select active while idle");
    sclk_role_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        $past(!cfg_master) |-> sclk_oe_n)
        else $error("slave drove clock");
    bit_count_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        cnt_q <= 6'h20)
        else $error("bit count above word length");
    ss_event_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (!ss_s && ss_sd) |=> irq_status[IRQ_SS])
        else $error("select event missed");
    tx_empty_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (tx_lvl == '0) |=> irq_status[IRQ_TX_E])
        else $error("tx empty event missed");
endmodule
`default_nettype wire

// file: src/ssc_fifo.sv
// Synchronous word FIFO with valid/ready on both sides and a fill level.
// Assumes one clock shared by writer and reader.
`timescale 1ns/1ps
`default_nettype none
module ssc_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 16,
    parameter int unsigned AW    = 4
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             arst_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    // Level
    output logic [AW:0]           level
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q < (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_q[rd_q];
    assign level     = cnt_q;

    always_ff @(posedge core_clk)
    begin
        if (push)
            mem_q[wr_q] <= in_data;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= wr_q + 1'b1;
            if (pop)
                rd_q <= rd_q + 1'b1;
            if (push && !pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop && !push)
                cnt_q <= cnt_q - 1'b1;
        end
    end

    fifo_bound_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        cnt_q <= (AW+1)'(DEPTH))
        else $error("fifo level above depth");
endmodule
`default_nettype wire
